//--- sab_pkg.sv
// shared constants for the converter control and its bus host
package sab_pkg;
    // converter core
    localparam int SAR_W        = 17;  // approximation register width
    localparam int CAL_DEPTH    = 17;  // calibration words, one per bit
    localparam int CAL_AW       = 5;   // calibration word address width
    localparam int RES_W        = 14;  // result width on the bus
    localparam int BYTE_W       = 8;   // low byte width
    localparam int PAIR_SPAN    = 4;   // distance between paired bits
    localparam int PAIR_TRIALS  = 13;  // trials done on bit pairs
    localparam int TRIALS_FULL  = 17;  // trials for a 14-bit result
    localparam int TRIALS_SHORT = 15;  // trials for a 12-bit result
    localparam int AZ_CLOCKS    = 3;   // auto-zero and clear clocks
    localparam int CONV_FULL    = TRIALS_FULL + AZ_CLOCKS;
    localparam int CNT_W        = 5;   // step counter width
    // host register port
    localparam int REG_AW       = 4;
    localparam int REG_DW       = 16;
    localparam logic [REG_AW-1:0] ADDR_CTRL     = 4'h0;
    localparam logic [REG_AW-1:0] ADDR_STATUS   = 4'h1;
    localparam logic [REG_AW-1:0] ADDR_RESULT   = 4'h2;
    localparam logic [REG_AW-1:0] ADDR_IRQ_STAT = 4'h3;
    localparam logic [REG_AW-1:0] ADDR_IRQ_CLR  = 4'h4;
    localparam logic [REG_AW-1:0] ADDR_IRQ_EN   = 4'h5;
    // control fields
    localparam int CTRL_START   = 0;
    localparam int CTRL_METH    = 1;   // two bits
    localparam int CTRL_WIDE    = 3;
    localparam int CTRL_FULL    = 4;
    localparam logic [1:0] METH_WAIT = 2'h0;
    localparam logic [1:0] METH_POLL = 2'h1;
    localparam logic [1:0] METH_IRQ  = 2'h2;
    // status and interrupt fields
    localparam int STAT_BUSY    = 0;
    localparam int STAT_EOC     = 1;
    localparam int IRQ_W        = 2;
    localparam int IRQ_DONE     = 0;   // result captured
    localparam int IRQ_RESTART  = 1;   // start issued while busy
endpackage

//--- sab_bus_if.sv
// bus pins between the converter and its host
`timescale 1ns/1ps
`default_nettype none
interface sab_bus_if;
    import sab_pkg::*;
    logic             csN;
    logic             wrN;
    logic             rdN;
    logic             byteSel;
    logic             busWide;
    logic             fullLengthSel;
    logic             eoc;
    logic [RES_W-1:0] dataOut;
    logic             dataLowOe;
    logic             dataHighOe;
    logic             overRangeOut;
    logic             overRangeOe;
    logic [RES_W-1:0] dataBus;
    logic             overRangeBus;

    // wired bus level; undriven lines read low
    assign dataBus[BYTE_W-1:0]     = dataLowOe ? dataOut[BYTE_W-1:0] : '0;
    assign dataBus[RES_W-1:BYTE_W] = dataHighOe ? dataOut[RES_W-1:BYTE_W] : '0;
    assign overRangeBus            = overRangeOe & overRangeOut;

    modport dev (
        input  csN, wrN, rdN, byteSel, busWide, fullLengthSel,
        output eoc, dataOut, dataLowOe, dataHighOe, overRangeOut, overRangeOe
    );
    modport host (
        output csN, wrN, rdN, byteSel, busWide, fullLengthSel,
        input  eoc, dataBus, overRangeBus
    );
endinterface
`default_nettype wire

//--- sab_device.sv
// converter control: start decode, paired trials, accumulation, bus output
`timescale 1ns/1ps
`default_nettype none
module sab_device (
    input  wire logic                          clk,
    input  wire logic                          rst,
    sab_bus_if.dev                             bus,
    input  wire logic                          compIn,
    output logic [sab_pkg::SAR_W-1:0]          dacCode,
    output logic                               autoZero,
    input  wire logic                          calWrEn,
    input  wire logic [sab_pkg::CAL_AW-1:0]    calAddr,
    input  wire logic [sab_pkg::SAR_W-1:0]     calData
);
    import sab_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_TRIAL, ST_AZERO} sab_conv_t;

    // elaboration guard on the sequence shape
    if (PAIR_TRIALS + PAIR_SPAN != SAR_W || TRIALS_FULL > SAR_W
        || TRIALS_SHORT > TRIALS_FULL || CAL_DEPTH != SAR_W) begin : g_check
        $error("sab_device: sequence constants do not fit the register");
    end

    logic [SAR_W-1:0] calTable [CAL_DEPTH];
    sab_conv_t        state_reg;
    logic [CNT_W-1:0] step_reg;
    logic [SAR_W-1:0] sar_reg;
    logic [SAR_W-1:0] sar_next;
    logic [SAR_W:0]   acc_reg;
    logic [SAR_W:0]   acc_next;
    logic             cmdLow_reg;
    logic             eoc_reg;
    logic [RES_W-1:0] result_reg;
    logic             overRange_reg;
    logic             cmdLow;
    logic             startNow;
    logic             readEn;
    logic             lastTrial;
    logic [CNT_W-1:0] lastStep;

    // bit under trial, counted from the top
    function automatic logic [CAL_AW-1:0] hiBit(input logic [CNT_W-1:0] step);
        return CAL_AW'(SAR_W - 1 - int'(step));
    endfunction

    // bits set for one trial: a pair early on, single at the end
    function automatic logic [SAR_W-1:0] trialMask(input logic [CNT_W-1:0] step);
        logic [SAR_W-1:0] m;
        m = '0;
        m[hiBit(step)] = 1'b1;
        if (int'(step) < PAIR_TRIALS) begin
            m[hiBit(step) - CAL_AW'(PAIR_SPAN)] = 1'b1;
        end
        return m;
    endfunction

    // start decode: a fresh low on write while selected
    assign cmdLow   = !bus.csN && !bus.wrN;
    assign startNow = cmdLow && !cmdLow_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            cmdLow_reg <= 1'b0;
        end else begin
            cmdLow_reg <= cmdLow;
        end
    end

    // length of the trial phase follows the length select
    assign lastStep  = bus.fullLengthSel ? CNT_W'(TRIALS_FULL - 1)
                                         : CNT_W'(TRIALS_SHORT - 1);
    assign lastTrial = (state_reg == ST_TRIAL) && (step_reg == lastStep);

    // trial decision and accumulation of the addressed word
    always_comb begin
        sar_next = sar_reg & ~trialMask(step_reg);
        acc_next = acc_reg;
        if (compIn) begin
            sar_next[hiBit(step_reg)] = 1'b1;
            acc_next = acc_reg + {1'b0, calTable[hiBit(step_reg)]};
        end
        if (!lastTrial) begin
            sar_next = sar_next | trialMask(step_reg + CNT_W'(1));
        end
    end

    // sequencer: trials, then auto-zero, then idle
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            step_reg  <= '0;
        end else if (startNow) begin
            state_reg <= ST_TRIAL;
            step_reg  <= '0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    step_reg <= '0;
                end
                ST_TRIAL: begin
                    if (lastTrial) begin
                        state_reg <= ST_AZERO;
                        step_reg  <= '0;
                    end else begin
                        step_reg <= step_reg + CNT_W'(1);
                    end
                end
                ST_AZERO: begin
                    if (step_reg == CNT_W'(AZ_CLOCKS - 1)) begin
                        state_reg <= ST_IDLE;
                        step_reg  <= '0;
                    end else begin
                        step_reg <= step_reg + CNT_W'(1);
                    end
                end
            endcase
        end
    end

    // approximation register
    always_ff @(posedge clk) begin
        if (rst) begin
            sar_reg <= '0;
        end else if (startNow) begin
            sar_reg <= trialMask('0);
        end else if (state_reg == ST_TRIAL) begin
            sar_reg <= sar_next;
        end else if (state_reg == ST_AZERO) begin
            sar_reg <= '0;
        end
    end

    // accumulator with carry on top
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_reg <= '0;
        end else if (startNow) begin
            acc_reg <= '0;
        end else if (state_reg == ST_TRIAL) begin
            acc_reg <= acc_next;
        end else if (state_reg == ST_AZERO) begin
            acc_reg <= '0;
        end
    end

    // output register takes the final sum
    always_ff @(posedge clk) begin
        if (rst) begin
            result_reg    <= '0;
            overRange_reg <= 1'b0;
        end else if (lastTrial && !startNow) begin
            result_reg    <= acc_next[SAR_W-1 -: RES_W];
            overRange_reg <= acc_next[SAR_W];
        end
    end

    // end flag: low from start, high when the result lands
    always_ff @(posedge clk) begin
        if (rst) begin
            eoc_reg <= 1'b1;
        end else if (startNow) begin
            eoc_reg <= 1'b0;
        end else if (lastTrial) begin
            eoc_reg <= 1'b1;
        end
    end

    // calibration table load port, no reset on the array
    always_ff @(posedge clk) begin
        if (calWrEn && int'(calAddr) < CAL_DEPTH) begin
            calTable[calAddr] <= calData;
        end
    end

    // three-state control of the data and over-range pins; end flag always driven
    assign readEn         = !bus.csN && !bus.rdN;
    assign bus.dataLowOe  = readEn && (bus.busWide || !bus.byteSel);
    assign bus.dataHighOe = readEn && (bus.busWide || bus.byteSel);
    assign bus.overRangeOe = bus.dataHighOe;
    assign bus.dataOut      = result_reg;
    assign bus.overRangeOut = overRange_reg;
    assign bus.eoc          = eoc_reg;

    // analog side: trial code and auto-zero phase
    assign dacCode  = sar_reg;
    assign autoZero = (state_reg == ST_AZERO);
endmodule // sab_device
`default_nettype wire

//--- sab_host.sv
// bus host: starts conversions and fetches results by wait, poll or flag
`timescale 1ns/1ps
`default_nettype none
module sab_host #(
    parameter int WAIT_CYCLES = sab_pkg::CONV_FULL + 1
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    sab_bus_if.host                            bus,
    input  wire logic [sab_pkg::REG_AW-1:0]    regAddr,
    input  wire logic [sab_pkg::REG_DW-1:0]    regWrData,
    input  wire logic                          regWrStb,
    input  wire logic                          regRdStb,
    output logic [sab_pkg::REG_DW-1:0]         regRdData,
    output logic                               irq
);
    import sab_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE, H_START, H_WAIT, H_POLL, H_RD_LO, H_RD_HI, H_RD_WIDE
    } sab_host_t;

    // wait must outlast a full conversion
    if (WAIT_CYCLES <= CONV_FULL || WAIT_CYCLES > 255) begin : g_check
        $error("sab_host: WAIT_CYCLES out of range");
    end

    sab_host_t        state_reg;
    logic [7:0]       wait_reg;
    logic [1:0]       meth_reg;
    logic             wide_reg;
    logic             full_reg;
    logic [RES_W:0]   result_reg;
    logic [IRQ_W-1:0] irqStat_reg;
    logic [IRQ_W-1:0] irqEn_reg;
    logic [REG_DW-1:0] rdData_reg;
    logic [IRQ_W-1:0] events;
    logic             startCmd;
    logic             readDone;

    assign startCmd = regWrStb && regAddr == ADDR_CTRL && regWrData[CTRL_START];
    assign readDone = state_reg == H_RD_HI || state_reg == H_RD_WIDE;

    // control register
    always_ff @(posedge clk) begin
        if (rst) begin
            meth_reg <= METH_WAIT;
            wide_reg <= 1'b0;
            full_reg <= 1'b1;
        end else if (regWrStb && regAddr == ADDR_CTRL) begin
            meth_reg <= regWrData[CTRL_METH +: 2];
            wide_reg <= regWrData[CTRL_WIDE];
            full_reg <= regWrData[CTRL_FULL];
        end
    end

    // transfer sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= H_IDLE;
        end else if (startCmd) begin
            state_reg <= H_START;
        end else begin
            unique case (state_reg)
                H_IDLE: ;
                H_START: state_reg <= (meth_reg == METH_POLL) ? H_POLL : H_WAIT;
                H_WAIT: begin
                    if (meth_reg == METH_IRQ ? bus.eoc
                        : wait_reg == 8'(WAIT_CYCLES - 1)) begin
                        state_reg <= wide_reg ? H_RD_WIDE : H_RD_LO;
                    end
                end
                H_POLL: if (bus.eoc) state_reg <= wide_reg ? H_RD_WIDE : H_RD_LO;
                H_RD_LO: state_reg <= H_RD_HI;
                H_RD_HI: state_reg <= H_IDLE;
                H_RD_WIDE: state_reg <= H_IDLE;
            endcase
        end
    end

    // wait counter
    always_ff @(posedge clk) begin
        if (rst || state_reg != H_WAIT) begin
            wait_reg <= '0;
        end else begin
            wait_reg <= wait_reg + 8'h01;
        end
    end

    // result capture from the bus
    always_ff @(posedge clk) begin
        if (rst) begin
            result_reg <= '0;
        end else if (state_reg == H_RD_LO) begin
            result_reg[BYTE_W-1:0] <= bus.dataBus[BYTE_W-1:0];
        end else if (state_reg == H_RD_HI) begin
            result_reg[RES_W:BYTE_W] <= {bus.overRangeBus, bus.dataBus[RES_W-1:BYTE_W]};
        end else if (state_reg == H_RD_WIDE) begin
            result_reg <= {bus.overRangeBus, bus.dataBus};
        end
    end

    // bus strobes from the sequencer state, length select from the control register
    assign bus.csN     = state_reg == H_IDLE || state_reg == H_WAIT;
    assign bus.wrN     = state_reg != H_START;
    assign bus.rdN     = !(state_reg == H_POLL || state_reg == H_RD_LO || readDone);
    assign bus.byteSel = state_reg == H_POLL || state_reg == H_RD_HI;
    assign bus.busWide = state_reg == H_RD_WIDE;
    assign bus.fullLengthSel = full_reg;

    // sticky events, set wins over clear
    always_comb begin
        events = '0;
        events[IRQ_DONE]    = readDone;
        events[IRQ_RESTART] = startCmd && state_reg != H_IDLE;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irqStat_reg <= '0;
            irqEn_reg   <= '0;
        end else begin
            irqStat_reg <= (irqStat_reg & ~((regWrStb && regAddr == ADDR_IRQ_CLR)
                           ? regWrData[IRQ_W-1:0] : '0)) | events;
            if (regWrStb && regAddr == ADDR_IRQ_EN) irqEn_reg <= regWrData[IRQ_W-1:0];
        end
    end
    assign irq = |(irqStat_reg & irqEn_reg);

    // read data one cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst || !regRdStb) begin
            rdData_reg <= '0;
        end else begin
            unique case (regAddr)
                ADDR_CTRL: rdData_reg <= REG_DW'({full_reg, wide_reg, meth_reg, 1'b0});
                ADDR_STATUS: rdData_reg <= REG_DW'({bus.eoc, state_reg != H_IDLE});
                ADDR_RESULT: rdData_reg <= REG_DW'(result_reg);
                ADDR_IRQ_STAT: rdData_reg <= REG_DW'(irqStat_reg);
                ADDR_IRQ_EN: rdData_reg <= REG_DW'(irqEn_reg);
                default: rdData_reg <= '0;
            endcase
        end
    end
    assign regRdData = rdData_reg;
endmodule // sab_host
`default_nettype wire

//--- sab_properties.sv
// concurrent checks on the converter bus between device and host
`timescale 1ns/1ps
`default_nettype none
module sab_properties (
    input wire logic                      clk,
    input wire logic                      rst,
    input wire logic                      csN,
    input wire logic                      wrN,
    input wire logic                      rdN,
    input wire logic                      byteSel,
    input wire logic                      busWide,
    input wire logic                      fullLengthSel,
    input wire logic                      eoc,
    input wire logic [sab_pkg::RES_W-1:0] dataOut,
    input wire logic                      dataLowOe,
    input wire logic                      dataHighOe,
    input wire logic                      overRangeOut,
    input wire logic                      overRangeOe
);
    import sab_pkg::*;
    logic       startS;
    logic       readLow;
    logic [4:0] cntReg;
    logic       fullReg;
    logic [4:0] lastCnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // start request, read select and the cycle where the result lands
    assign startS  = !csN && !wrN;
    assign readLow = !csN && !rdN;
    assign lastCnt = fullReg ? 5'h12 : 5'h10;
    // cycles since the last accepted start, restarted by a new one
    always_ff @(posedge clk) begin
        if (rst) begin
            cntReg <= 5'h00;
        end else if (startS) begin
            cntReg <= 5'h01;
        end else if (cntReg != 5'h00 && cntReg != 5'h1f) begin
            cntReg <= cntReg + 5'h01;
        end
    end
    // length chosen when the start is taken
    always_ff @(posedge clk) begin
        if (startS) begin
            fullReg <= fullLengthSel;
        end
    end
    // output enables
    deselect_quiet_a: assert property (csN |-> !dataLowOe && !dataHighOe)
        else $error("data enabled while deselected");
    read_idle_quiet_a: assert property (rdN |-> !dataLowOe && !dataHighOe && !overRangeOe)
        else $error("data enabled with read high");
    low_byte_a: assert property (readLow && !busWide && !byteSel
        |-> dataLowOe && !dataHighOe)
        else $error("low byte not steered");
    high_byte_a: assert property (readLow && !busWide && byteSel
        |-> dataHighOe && !dataLowOe)
        else $error("high byte not steered");
    wide_both_a: assert property (readLow && busWide |-> dataLowOe && dataHighOe)
        else $error("wide read missing a byte");
    range_with_high_a: assert property (overRangeOe == dataHighOe)
        else $error("overrange enable apart from high byte");
    // start and conversion timing
    start_pulse_a: assert property ($fell(wrN) |=> wrN)
        else $error("start strobe longer than one cycle");
    busy_after_start_a: assert property (startS |=> !eoc [*2])
        else $error("end flag not low after start");
    busy_trials_a: assert property (cntReg != 5'h00 && cntReg < lastCnt |-> !eoc)
        else $error("end flag high during trials");
    done_on_time_a: assert property (cntReg == lastCnt |-> $rose(eoc))
        else $error("end flag did not rise on time");
    done_only_then_a: assert property ($rose(eoc) |-> cntReg == lastCnt)
        else $error("end flag rose at wrong count");
    result_hold_a: assert property (!$rose(eoc) |-> $stable({overRangeOut, dataOut}))
        else $error("result changed outside latch");
endmodule // sab_properties
`default_nettype wire

//--- tb.sv
// self-checking bench: host and device joined, comparator and table modelled here
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sab_pkg::*;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              compIn = 1'b0;
    logic              calWrEn = 1'b0;
    logic [CAL_AW-1:0] calAddr = '0;
    logic [SAR_W-1:0]  calData = '0;
    logic [REG_AW-1:0] regAddr = '0;
    logic [REG_DW-1:0] regWrData = '0;
    logic              regWrStb = 1'b0;
    logic              regRdStb = 1'b0;
    logic [REG_DW-1:0] regRdData;
    logic              irq;
    logic [SAR_W-1:0]  dacCode;
    logic              autoZero;
    int                azCount = 0;
    logic [SAR_W-1:0]  mask = '0;
    logic [REG_DW-1:0] curExp = '0;
    logic [REG_DW-1:0] rd;
    int                calTab[SAR_W];
    int                step = 0;
    int                errCount = 0;
    int                totalChecks = 0;

    sab_bus_if busIf();
    sab_device sab_device_inst (
        .clk(clk), .rst(rst), .bus(busIf), .compIn(compIn), .dacCode(dacCode),
        .autoZero(autoZero), .calWrEn(calWrEn), .calAddr(calAddr), .calData(calData)
    );
    sab_host sab_host_inst (
        .clk(clk), .rst(rst), .bus(busIf), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .irq(irq)
    );
    sab_properties sab_properties_inst (
        .clk(clk), .rst(rst), .csN(busIf.csN), .wrN(busIf.wrN), .rdN(busIf.rdN),
        .byteSel(busIf.byteSel), .busWide(busIf.busWide), .fullLengthSel(busIf.fullLengthSel),
        .eoc(busIf.eoc), .dataOut(busIf.dataOut), .dataLowOe(busIf.dataLowOe),
        .dataHighOe(busIf.dataHighOe), .overRangeOut(busIf.overRangeOut),
        .overRangeOe(busIf.overRangeOe)
    );

    // clock
    initial begin
        forever #25 clk = ~clk;
    end

    // comparator: trial k after the start decides bit 17-k from the mask
    always @(posedge clk) begin
        int ns;
        ns = (!busIf.csN && !busIf.wrN) ? 1 : (step != 0 && step < SAR_W) ? step + 1 : 0;
        step <= ns;
        compIn <= (ns != 0) ? mask[SAR_W-ns] : 1'($urandom);
    end

    // bus level on every read of a finished result
    always @(negedge clk) begin
        logic [REG_DW-1:0] busGot;
        logic [REG_DW-1:0] busExp;
        busGot = {1'b0, busIf.overRangeBus, busIf.dataBus};
        busExp = busIf.byteSel ? {curExp[15:8], 8'h00} : {8'h00, curExp[7:0]};
        busExp = busIf.busWide ? curExp : busExp;
        if (!busIf.csN && !busIf.rdN && busIf.eoc === 1'b1) begin
            checkVal(busGot, busExp, "bus");
        end
    end

    // auto-zero length, cleared register after it, first pair after each start
    always @(negedge clk) begin
        if (autoZero === 1'b1) begin
            azCount <= azCount + 1;
        end else if (azCount != 0) begin
            azCount <= 0;
            checkVal(REG_DW'(azCount), REG_DW'(AZ_CLOCKS), "auto-zero clocks");
            checkVal({15'h0000, dacCode == '0}, 16'h0001, "register cleared");
        end
        if (step == 1) begin
            checkVal({15'h0000, dacCode == 17'h11000}, 16'h0001, "first pair");
        end
    end

    task automatic endSim();
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic checkVal(logic [REG_DW-1:0] got, logic [REG_DW-1:0] exp, string what);
        totalChecks++;
        if (got !== exp) begin
            errCount++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // sum of table words for every kept bit; short runs stop before bit 1
    function automatic logic [REG_DW-1:0] expectResult(logic [SAR_W-1:0] m, int full);
        int acc;
        acc = 0;
        for (int b = (full != 0) ? 0 : 2; b < SAR_W; b++) begin
            if (m[b]) begin
                acc += calTab[b];
            end
        end
        return {1'b0, acc[17], acc[16:3]};
    endfunction

    task automatic regWrite(logic [REG_AW-1:0] a, logic [REG_DW-1:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge clk);
        regWrStb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic regRead(logic [REG_AW-1:0] a, output logic [REG_DW-1:0] d);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge clk);
        regRdStb <= 1'b0;
        @(negedge clk);
        d = regRdData;
        @(posedge clk);
    endtask

    task automatic checkIrq(logic e);
        @(negedge clk);
        checkVal({15'h0000, irq}, {15'h0000, e}, "irq");
        @(posedge clk);
    endtask

    task automatic waitIrq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n == 100) begin
            errCount++;
            $display("CHECK FAILED at %0t: no interrupt", $time);
            endSim();
        end
    endtask

    // one conversion, optionally restarted seven cycles in
    task automatic convert(int meth, int wide, int full, int restart);
        logic [REG_DW-1:0] ctrl;
        logic [SAR_W-1:0]  m;
        ctrl = REG_DW'(1 + meth * 2 + wide * 8 + full * 16);
        // restart event masked so only the done event ends the wait
        if (restart != 0) begin
            regWrite(ADDR_IRQ_EN, 16'h0001);
        end
        repeat (restart + 1) begin
            m = SAR_W'($urandom);
            mask <= m;
            curExp = expectResult(m, full);
            regWrite(ADDR_CTRL, ctrl);
            repeat (5 * restart) @(posedge clk);
        end
        waitIrq();
        regRead(ADDR_RESULT, rd);
        checkVal(rd, curExp, "result");
        regRead(ADDR_IRQ_STAT, rd);
        checkVal(rd, REG_DW'(1 + restart * 2), "events");
        regWrite(ADDR_IRQ_EN, 16'h0000);
        checkIrq(1'b0);
        regWrite(ADDR_IRQ_EN, 16'h0003);
        checkIrq(1'b1);
        regWrite(ADDR_IRQ_CLR, 16'h0003);
        checkIrq(1'b0);
        repeat (4) @(posedge clk);
    endtask

    // main sequence
    initial begin
        void'($urandom(32'hdd5853c7));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        regRead(ADDR_STATUS, rd);
        checkVal(rd, 16'h0002, "idle status");
        regRead(4'hf, rd);
        checkVal(rd, 16'h0000, "unmapped read");
        for (int b = 0; b < SAR_W; b++) begin
            calTab[b] = $urandom_range(15000);
            calWrEn <= 1'b1;
            calAddr <= CAL_AW'(b);
            calData <= SAR_W'(calTab[b]);
            @(posedge clk);
        end
        calWrEn <= 1'b0;
        regWrite(ADDR_IRQ_EN, 16'h0003);
        regRead(ADDR_IRQ_EN, rd);
        checkVal(rd, 16'h0003, "irq enable");
        for (int i = 0; i < 12; i++) begin
            convert(i % 3, (i / 3) % 2, i / 6, 0);
        end
        convert(1, 0, 1, 1);
        convert(1, 1, 0, 1);
        // reset in mid conversion
        regWrite(ADDR_CTRL, 16'h0011);
        repeat (4) @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        regRead(ADDR_STATUS, rd);
        checkVal(rd, 16'h0002, "status after reset");
        endSim();
    end
endmodule // tb
`default_nettype wire
